// File: hw/hrp_pkg.sv
// Constants, register map and field layout of the fine edge positioner.
// Assumes one system clock at 100 MHz and a time base outside this block.
package hrp_pkg;
    // ==========================================================
    // Widths
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 16;
    localparam int FINE_W = 8;
    localparam int WIN_W  = 3;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] CFG_OFS       = 6'h00;
    localparam logic [ADDR_W-1:0] CMP_OFS       = 6'h04;
    localparam logic [ADDR_W-1:0] LOCK_OFS      = 6'h08;
    localparam logic [ADDR_W-1:0] DIAG_CTRL_OFS = 6'h0c;
    localparam logic [ADDR_W-1:0] DIAG_STAT_OFS = 6'h10;
    localparam logic [ADDR_W-1:0] STAT_OFS      = 6'h14;

    // Writing this word opens the protected registers; any other closes
    localparam logic [DATA_W-1:0] UNLOCK_KEY = 32'h0000_a5a5;

    // ==========================================================
    // Field positions
    localparam int CFG_EN_BIT    = 0;
    localparam int CFG_EDGE_LSB  = 1;
    localparam int CFG_SRC_BIT   = 3;
    localparam int CFG_LOAD_LSB  = 4;
    localparam int CFG_W         = 6;
    localparam int CMP_COARSE_LSB = 16;
    localparam int CMP_FINE_LSB  = 8;
    localparam int DIAG_GO_BIT   = 0;
    localparam int DIAG_CODE_LSB = 8;
    localparam logic [CFG_W-1:0] CFG_RST = 6'h00;

    // ==========================================================
    // Field encodings
    typedef enum logic [1:0] {
        HRP_EDGE_OFF  = 2'h0,
        HRP_EDGE_RISE = 2'h1,
        HRP_EDGE_FALL = 2'h2
    } hrp_edge_type;

    typedef enum logic {
        HRP_SRC_FRACTION = 1'h0,
        HRP_SRC_DIAG     = 1'h1
    } hrp_src_type;

    typedef enum logic [1:0] {
        HRP_LOAD_ZERO      = 2'h0,
        HRP_LOAD_PERIOD    = 2'h1,
        HRP_LOAD_ZERO_PRD  = 2'h2,
        HRP_LOAD_IMMEDIATE = 2'h3
    } hrp_load_type;

    // ==========================================================
    // Timing, in system clock cycles, and fine delay step counts
    localparam logic [WIN_W-1:0] WIN_PLAIN_CYC = 3'h3;
    localparam logic [WIN_W-1:0] WIN_CAL_CYC   = 3'h6;
    localparam int               FINE_STEPS    = 255;
    localparam logic [FINE_W-1:0] FINE_MAX     = 8'hff;
    localparam logic [1:0]       CAL_SETTLE_CYC = 2'h3;
endpackage : hrp_pkg

// File: hw/hrp_scale_cal.sv
// Self-check that counts fine delay steps in one system clock period.
// Assumes the delay line reports, asynchronously, a launched edge that
// arrived after the next clock edge.
`timescale 1ns/100ps
module hrp_scale_cal (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // Control
    input  wire logic                       start,
    // Delay line test path
    input  wire logic                       probe_late,
    output logic                            probe_launch,
    output logic [hrp_pkg::FINE_W-1:0]      probe_code,
    // Result
    output logic                            running,
    output logic                            done,
    output logic [hrp_pkg::FINE_W-1:0]      steps_per_coarse_cycle
);
    import hrp_pkg::*;

    typedef enum logic [3:0] {
        CAL_IDLE   = 4'h1,
        CAL_LAUNCH = 4'h2,
        CAL_SETTLE = 4'h4,
        CAL_CHECK  = 4'h8
    } hrp_cal_state_type;

    typedef struct packed {
        hrp_cal_state_type state;
        logic              late_meta;
        logic              late_sync;
        logic [1:0]        settle;
        logic [FINE_W-1:0] code;
        logic              launch;
        logic              done;
        logic [FINE_W-1:0] result;
    } hrp_cal_type;

    hrp_cal_type s_reg;
    hrp_cal_type s_next;

    always_comb begin
        s_next           = s_reg;
        s_next.launch    = 1'b0;
        s_next.late_meta = probe_late;
        s_next.late_sync = s_reg.late_meta;
        case (s_reg.state)
            CAL_IDLE: begin
                if (start) begin
                    s_next.code  = 8'h01;
                    s_next.done  = 1'b0;
                    s_next.state = CAL_LAUNCH;
                end
            end
            CAL_LAUNCH: begin
                s_next.launch = 1'b1;
                s_next.settle = 2'h0;
                s_next.state  = CAL_SETTLE;
            end
            // Wait out the two-flop synchroniser before judging
            CAL_SETTLE: begin
                s_next.settle = s_reg.settle + 2'h1;
                if (s_reg.settle == CAL_SETTLE_CYC) begin
                    s_next.state = CAL_CHECK;
                end
            end
            CAL_CHECK: begin
                if (s_reg.late_sync || s_reg.code == FINE_MAX) begin
                    s_next.result = s_reg.code;
                    s_next.done   = 1'b1;
                    s_next.state  = CAL_IDLE;
                end else begin
                    s_next.code  = s_reg.code + 8'h01;
                    s_next.state = CAL_LAUNCH;
                end
            end
            default: s_next.state = CAL_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg       <= '0;
            s_reg.state <= CAL_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign probe_launch           = s_reg.launch;
    assign probe_code             = s_reg.code;
    assign running                = s_reg.state != CAL_IDLE;
    assign done                   = s_reg.done;
    assign steps_per_coarse_cycle = s_reg.result;
endmodule : hrp_scale_cal

// File: hw/hrp_edge_positioner.sv
// Fine edge positioner for output channel A of a counter-based PWM.
// Assumes an outer time base on the same clock that gives the count,
// zero and period strobes and the count direction.
`timescale 1ns/100ps
module hrp_edge_positioner #(
    parameter int WIN_PLAIN = 3,
    parameter int WIN_CAL   = 6
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // Register port
    input  wire logic [hrp_pkg::ADDR_W-1:0] addr,
    input  wire logic [hrp_pkg::DATA_W-1:0] wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic [hrp_pkg::DATA_W-1:0]      rdata,
    // Time base
    input  wire logic [hrp_pkg::CNT_W-1:0]  tb_count,
    input  wire logic                       tb_at_zero,
    input  wire logic                       tb_at_period,
    input  wire logic                       tb_count_down,
    // Fine delay line
    output logic                            output_channel_a,
    output logic [hrp_pkg::FINE_W-1:0]      fine_edge_delay_line,
    output logic                            delay_rise_en,
    output logic                            delay_fall_en,
    // Calibration probe of the delay line
    input  wire logic                       probe_late,
    output logic                            probe_launch,
    output logic [hrp_pkg::FINE_W-1:0]      probe_code
);
    import hrp_pkg::*;

    // ==========================================================
    // Parameter checks
    if (WIN_PLAIN < 1 || WIN_PLAIN > 7 || WIN_CAL < WIN_PLAIN
        || WIN_CAL > 7) begin : g_bad_win
        $error("window counts must satisfy 1 <= plain <= cal <= 7");
    end
    if (FINE_STEPS != 255) begin : g_bad_steps
        $error("fine step code must cover 255 steps");
    end

    localparam logic [WIN_W-1:0] WIN_P = WIN_W'(WIN_PLAIN);
    localparam logic [WIN_W-1:0] WIN_C = WIN_W'(WIN_CAL);

    // ==========================================================
    // State
    typedef struct packed {
        logic [CFG_W-1:0]  cfg;
        logic              unlocked;
        logic [CNT_W-1:0]  coarse_shadow;
        logic [FINE_W-1:0] fine_shadow;
        logic [CNT_W-1:0]  coarse_active;
        logic [FINE_W-1:0] fine_active;
        logic [FINE_W-1:0] diag_code;
        logic              cal_go;
        logic [WIN_W-1:0]  win_cnt;
        logic              pwm;
        logic [FINE_W-1:0] delay_code;
        logic              rise_en;
        logic              fall_en;
        logic [DATA_W-1:0] rdata;
    } hrp_state_type;

    hrp_state_type s_reg;
    hrp_state_type s_next;

    logic              cal_running;
    logic              cal_done;
    logic [FINE_W-1:0] cal_steps;

    hrp_scale_cal u_cal (
        .clk                    (clk),
        .rst                    (rst),
        .start                  (s_reg.cal_go),
        .probe_late             (probe_late),
        .probe_launch           (probe_launch),
        .probe_code             (probe_code),
        .running                (cal_running),
        .done                   (cal_done),
        .steps_per_coarse_cycle (cal_steps)
    );

    // ==========================================================
    // Decoded configuration
    logic              hr_en;
    hrp_edge_type      edge_sel;
    hrp_src_type       src_sel;
    hrp_load_type      load_sel;
    logic              period_start;
    logic              load_fine;
    logic [FINE_W-1:0] fine_src;
    logic              match;
    logic              fine_ok;
    logic              pwm_new;
    logic [WIN_W-1:0]  win_lim;

    always_comb begin
        hr_en    = s_reg.cfg[CFG_EN_BIT];
        edge_sel = hrp_edge_type'(s_reg.cfg[CFG_EDGE_LSB +: 2]);
        src_sel  = hrp_src_type'(s_reg.cfg[CFG_SRC_BIT]);
        load_sel = hrp_load_type'(s_reg.cfg[CFG_LOAD_LSB +: 2]);
        // A down-counting period starts at the period value
        period_start = tb_count_down ? tb_at_period : tb_at_zero;
        case (load_sel)
            HRP_LOAD_ZERO:      load_fine = tb_at_zero;
            HRP_LOAD_PERIOD:    load_fine = tb_at_period;
            HRP_LOAD_ZERO_PRD:  load_fine = tb_at_zero || tb_at_period;
            HRP_LOAD_IMMEDIATE: load_fine = 1'b1;
            default:            load_fine = tb_at_zero;
        endcase
        fine_src = (src_sel == HRP_SRC_FRACTION) ? s_reg.fine_shadow
                                                 : s_reg.diag_code;
        win_lim  = cal_running ? WIN_C : WIN_P;
        match    = tb_count == s_reg.coarse_active;
        // Fine placement only once the start window has elapsed
        fine_ok  = hr_en && !period_start
                   && s_reg.win_cnt >= win_lim;
    end

    // ==========================================================
    // Next state
    always_comb begin
        s_next         = s_reg;
        s_next.cal_go  = 1'b0;
        s_next.rise_en = 1'b0;
        s_next.fall_en = 1'b0;
        s_next.rdata   = '0;

        // Register writes
        if (wr) begin
            case (addr)
                LOCK_OFS: s_next.unlocked = wdata == UNLOCK_KEY;
                CFG_OFS: begin
                    if (s_reg.unlocked) begin
                        s_next.cfg = wdata[CFG_W-1:0];
                    end
                end
                CMP_OFS: begin
                    // Coarse and fraction land together in one write
                    s_next.coarse_shadow =
                        wdata[CMP_COARSE_LSB +: CNT_W];
                    s_next.fine_shadow =
                        wdata[CMP_FINE_LSB +: FINE_W];
                end
                DIAG_CTRL_OFS: begin
                    // Only the unlocked calibration path reaches these
                    if (s_reg.unlocked) begin
                        s_next.cal_go    = wdata[DIAG_GO_BIT];
                        s_next.diag_code =
                            wdata[DIAG_CODE_LSB +: FINE_W];
                    end
                end
                default: ;
            endcase
        end

        // Register reads, answered in the next cycle
        if (rd) begin
            case (addr)
                CFG_OFS:  s_next.rdata = {{(DATA_W-CFG_W){1'b0}}, s_reg.cfg};
                CMP_OFS:  s_next.rdata = {s_reg.coarse_shadow,
                                          s_reg.fine_shadow, 8'h00};
                LOCK_OFS: s_next.rdata = {{(DATA_W-1){1'b0}},
                                          s_reg.unlocked};
                DIAG_CTRL_OFS: s_next.rdata = {16'h0000, s_reg.diag_code,
                                               7'h00, cal_running};
                DIAG_STAT_OFS: s_next.rdata = {16'h0000, cal_steps,
                                               7'h00, cal_done};
                STAT_OFS: s_next.rdata = {s_reg.coarse_active,
                                          s_reg.fine_active,
                                          4'h0, fine_ok, s_reg.win_cnt};
                default:  s_next.rdata = '0;
            endcase
        end

        // Shadow transfers
        if (period_start) begin
            s_next.coarse_active = s_reg.coarse_shadow;
        end
        if (load_fine) begin
            s_next.fine_active = fine_src;
        end

        // Start-of-period window counter, saturating; the start cycle
        // itself counts as the first elapsed cycle
        if (period_start) begin
            s_next.win_cnt = 3'h1;
        end else if (s_reg.win_cnt != {WIN_W{1'b1}}) begin
            s_next.win_cnt = s_reg.win_cnt + 3'h1;
        end

        // Coarse waveform; a compare hit on the start cycle wins, so
        // a zero compare gives 0% in count-up
        pwm_new = s_reg.pwm;
        if (tb_count_down) begin
            if (period_start) pwm_new = 1'b0;
            if (match) pwm_new = 1'b1;
        end else begin
            if (period_start) pwm_new = 1'b1;
            if (match) pwm_new = 1'b0;
        end
        s_next.pwm = pwm_new;

        // Fine delay on the selected edge of channel A only
        if (pwm_new && !s_reg.pwm) begin
            if (edge_sel == HRP_EDGE_RISE && fine_ok) begin
                s_next.rise_en    = 1'b1;
                s_next.delay_code = s_reg.fine_active;
            end else begin
                s_next.delay_code = '0;
            end
        end else if (!pwm_new && s_reg.pwm) begin
            if (edge_sel == HRP_EDGE_FALL && fine_ok) begin
                s_next.fall_en    = 1'b1;
                s_next.delay_code = s_reg.fine_active;
            end else begin
                s_next.delay_code = '0;
            end
        end
        if (!hr_en) begin
            s_next.delay_code = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg     <= '0;
            s_reg.cfg <= CFG_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // Outputs
    assign rdata                = s_reg.rdata;
    assign output_channel_a     = s_reg.pwm;
    assign fine_edge_delay_line = s_reg.delay_code;
    assign delay_rise_en        = s_reg.rise_en;
    assign delay_fall_en        = s_reg.fall_en;
endmodule : hrp_edge_positioner

// File: sim/hrp_edge_asserts.sv
// Concurrent checks on the ports of the fine edge positioner.
// Assumes one clock domain with a synchronous, active-high reset.
`timescale 1ns/100ps
module hrp_edge_asserts #(
    parameter int WIN_PLAIN = 3,
    parameter int WIN_CAL   = 6
) (
    // Clock and reset
    input wire logic                       clk,
    input wire logic                       rst,
    // Register port
    input wire logic [hrp_pkg::ADDR_W-1:0] addr,
    input wire logic                       rd,
    input wire logic [hrp_pkg::DATA_W-1:0] rdata,
    // Time base
    input wire logic                       tb_at_zero,
    input wire logic                       tb_at_period,
    input wire logic                       tb_count_down,
    // Outputs
    input wire logic                       output_channel_a,
    input wire logic                       delay_rise_en,
    input wire logic                       delay_fall_en,
    input wire logic                       probe_launch,
    input wire logic [hrp_pkg::FINE_W-1:0] probe_code
);
    import hrp_pkg::*;
    // ==========================================================
    // Cycles since period start, one cycle late, saturating at 7
    logic [2:0] win_reg;
    logic [2:0] win_next;
    logic       start;
    assign start = tb_count_down ? tb_at_period : tb_at_zero;
    always_comb begin
        win_next = win_reg;
        if (start) begin
            win_next = 3'h0;
        end else if (win_reg != 3'h7) begin
            win_next = win_reg + 3'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            win_reg <= 3'h0;
        end else begin
            win_reg <= win_next;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence fine_pulse;
        delay_rise_en || delay_fall_en;
    endsequence
    sequence settle_gap;
        !probe_launch [*4];
    endsequence
    rd_idle_a : assert property (!rd |=> rdata == '0)
        else $error("read data not zero outside a read answer");
    unmapped_rd_a : assert property (rd && addr == 6'h3c |=> rdata == '0)
        else $error("unmapped read returned data");
    edge_excl_a : assert property (!(delay_rise_en && delay_fall_en))
        else $error("both edge enables at once");
    fall_edge_a : assert property (delay_fall_en |-> $fell(output_channel_a))
        else $error("fall enable without falling output");
    rise_edge_a : assert property (delay_rise_en |-> $rose(output_channel_a))
        else $error("rise enable without rising output");
    fine_window_a : assert property (fine_pulse |-> win_reg >= WIN_PLAIN)
        else $error("fine edge inside start window");
    up_set_a : assert property ($rose(output_channel_a)
        && !$past(tb_count_down) |-> $past(tb_at_zero))
        else $error("count-up output rose away from period start");
    down_clear_a : assert property ($fell(output_channel_a)
        && $past(tb_count_down) |-> $past(tb_at_period))
        else $error("count-down output fell away from period start");
    probe_gap_a : assert property (probe_launch |=> settle_gap)
        else $error("test edges launched too close together");
    probe_hold_a : assert property (probe_launch |=> $stable(probe_code) [*3])
        else $error("test code moved while settling");
endmodule : hrp_edge_asserts

bind hrp_edge_positioner hrp_edge_asserts #(
    .WIN_PLAIN(WIN_PLAIN), .WIN_CAL(WIN_CAL)
) i_hrp_edge_asserts (
    .clk(clk), .rst(rst), .addr(addr), .rd(rd), .rdata(rdata),
    .tb_at_zero(tb_at_zero), .tb_at_period(tb_at_period),
    .tb_count_down(tb_count_down), .output_channel_a(output_channel_a),
    .delay_rise_en(delay_rise_en), .delay_fall_en(delay_fall_en),
    .probe_launch(probe_launch), .probe_code(probe_code)
);

// File: sim/hrp_delay_model.sv
// Behavioural model of the fine delay line test path.
// Assumes launch and code come from the positioner on the same clock.
`timescale 1ns/100ps
module hrp_delay_model #(
    parameter int STEPS = 40
) (
    // Clock
    input wire logic                       clk,
    // Test path
    input wire logic                       probe_launch,
    input wire logic [hrp_pkg::FINE_W-1:0] probe_code,
    output logic                           probe_late
);
    // ==========================================================
    // Late once the delay spans a clock; answer lands off the edge
    initial probe_late = 1'b0;
    always @(posedge clk) begin
        if (probe_launch) begin
            probe_late <= #2 (probe_code >= STEPS);
        end
    end
endmodule : hrp_delay_model

// File: sim/testbench.sv
// Self-checking bench for the fine edge positioner.
// Assumes the time base is modelled here with a short period.
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    bad_count++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module testbench;
    import hrp_pkg::*;
    // ==========================================================
    // Settings and signals
    localparam int PRD   = 15;
    localparam int STEPS = 40;
    localparam logic [5:0] EN = 6'(1) << CFG_EN_BIT;
    localparam logic [5:0] BASE = EN
        | (6'(HRP_SRC_FRACTION) << CFG_SRC_BIT)
        | (6'(HRP_LOAD_ZERO) << CFG_LOAD_LSB);
    localparam logic [5:0] FALL = BASE | (6'(HRP_EDGE_FALL) << CFG_EDGE_LSB);
    localparam logic [5:0] RISE = BASE | (6'(HRP_EDGE_RISE) << CFG_EDGE_LSB);
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [CNT_W-1:0]  tb_count = '0;
    logic              tb_count_down = 1'b0;
    logic              pwm;
    logic [FINE_W-1:0] code;
    logic              rise_en;
    logic              fall_en;
    logic              late;
    logic              launch;
    logic [FINE_W-1:0] pcode;
    logic [DATA_W-1:0] d;
    int                bad_count = 0;
    int                cmp_count = 0;
    int                cyc = 0;
    initial forever #5 clk = ~clk;
    // Time base: counts up to PRD, or down from it
    always_ff @(posedge clk) begin
        if (tb_count_down) begin
            tb_count <= (tb_count == 0) ? CNT_W'(PRD) : tb_count - 1'b1;
        end else begin
            tb_count <= (tb_count == PRD) ? '0 : tb_count + 1'b1;
        end
    end
    hrp_edge_positioner #(.WIN_PLAIN(3), .WIN_CAL(6)) i_hrp_edge_positioner (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .tb_count(tb_count),
        .tb_at_zero(tb_count == 0), .tb_at_period(tb_count == PRD),
        .tb_count_down(tb_count_down), .output_channel_a(pwm),
        .fine_edge_delay_line(code), .delay_rise_en(rise_en),
        .delay_fall_en(fall_en), .probe_late(late),
        .probe_launch(launch), .probe_code(pcode));
    hrp_delay_model #(.STEPS(STEPS)) i_delay (.clk(clk),
        .probe_launch(launch), .probe_code(pcode), .probe_late(late));
    // ==========================================================
    // Tasks
    task automatic wr_reg(input logic [5:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [5:0] a, output logic [31:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        // Data stand only in this cycle; take them once settled
        @(negedge clk);
        v = rdata;
        @(posedge clk);
    endtask : rd_reg
    // Settle three periods, then count one period of output
    task automatic pwm_chk(input int c, input int nr, input int nf,
                           input logic [7:0] ec);
        int hi, r, f;
        logic [7:0] seen;
        hi = 0;
        r = 0;
        f = 0;
        seen = 8'h00;
        repeat (3 * (PRD + 1)) @(posedge clk);
        repeat (PRD + 1) begin
            @(posedge clk);
            hi += int'(pwm === 1'b1);
            r += int'(rise_en === 1'b1);
            f += int'(fall_en === 1'b1);
            if (rise_en === 1'b1 || fall_en === 1'b1) seen = code;
        end
        `CHK("duty", c, hi)
        `CHK("rise pulses", nr, r)
        `CHK("fall pulses", nf, f)
        `CHK("step code", ec, seen)
    endtask : pwm_chk
    task automatic run(input logic [5:0] cf, input int c,
                       input logic [7:0] fn, input int nr, input int nf);
        wr_reg(CFG_OFS, {26'h0, cf});
        wr_reg(CMP_OFS, {c[15:0], fn, 8'hff});
        pwm_chk(c + int'(tb_count_down), nr, nf, (nr + nf > 0) ? fn : 8'h00);
    endtask : run
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    // Hang guard, well above the fewer than one thousand cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_reg(CFG_OFS, d);
        `CHK("config reset", 32'h0, d)
        wr_reg(CFG_OFS, {26'h0, FALL});
        rd_reg(CFG_OFS, d);
        `CHK("locked config", 32'h0, d)
        wr_reg(LOCK_OFS, UNLOCK_KEY);
        wr_reg(CFG_OFS, {26'h0, FALL});
        rd_reg(CFG_OFS, d);
        `CHK("config", {26'h0, FALL}, d)
        wr_reg(CMP_OFS, 32'h0003_41ff);
        rd_reg(CMP_OFS, d);
        `CHK("compare word", 32'h0003_4100, d)
        rd_reg(6'h3c, d);
        `CHK("unmapped", 32'h0, d)
        run(FALL, 0, 8'h11, 0, 0);
        run(FALL, 2, 8'h12, 0, 0);
        run(FALL, 3, 8'hff, 0, 1);
        // New step value waits for the next period start
        do @(posedge clk); while (tb_count != 1);
        wr_reg(CMP_OFS, 32'h0003_55ff);
        rd_reg(STAT_OFS, d);
        `CHK("active before zero", 24'h0003ff, d[31:8])
        pwm_chk(3, 0, 1, 8'h55);
        run(OFF_CFG(), 4, 8'h14, 0, 0);
        run(FALL, 4, 8'h24, 0, 1);
        wr_reg(DIAG_CTRL_OFS, 32'h1);
        pwm_chk(4, 0, 0, 8'h00);
        d = '0;
        for (int i = 0; i < 200 && d[0] !== 1'b1; i++) rd_reg(DIAG_STAT_OFS, d);
        `CHK("steps", {8'(STEPS), 1'b1}, {d[15:8], d[0]})
        pwm_chk(4, 0, 1, 8'h24);
        tb_count_down <= 1'b1;
        run(RISE, PRD - 2, 8'h31, 0, 0);
        run(RISE, PRD - 3, 8'h32, 1, 0);
        wr_reg(LOCK_OFS, 32'h0);
        wr_reg(DIAG_CTRL_OFS, 32'h1);
        rd_reg(DIAG_CTRL_OFS, d);
        `CHK("locked start", 1'b0, d[0])
        rd_reg(DIAG_STAT_OFS, d);
        `CHK("done kept", 1'b1, d[0])
        end_of_test();
    end
    function automatic logic [5:0] OFF_CFG();
        return 6'h00;
    endfunction : OFF_CFG
endmodule : testbench
